// ---- mss_defines.svh ----
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH

// value and counter widths
`define MSS_VALUE_W         12
`define MSS_FLASH_CNT_W     26

// switch encodings
`define MSS_LOCK_MANUAL     3'h2
`define MSS_LOCK_EDGE_A     3'h3
`define MSS_LOCK_EDGE_B     3'h4
`define MSS_SRC_SERIAL_A    3'h2
`define MSS_SRC_SERIAL_B    3'h3
`define MSS_STRUCT_TWO_POS  2'h1
`define MSS_STRUCT_INT_FB   2'h2

// flash timing: one flash period is 1000 ms
`define MSS_FLASH_PERIOD_MS 1000
`define MSS_CLK_HZ          50000000
`define MSS_FLASH_PERIOD_CYC ((`MSS_CLK_HZ / 1000) * `MSS_FLASH_PERIOD_MS)
// slow pulse: off for the first tenth, on for nine tenths
`define MSS_SLOW_OFF_DIV    10
// 1:1 flash: on for the first half
`define MSS_EVEN_DIV        2

// reset value, full-scale value and default step
`define MSS_VALUE_RESET     12'h000
`define MSS_VALUE_FULL      12'hFFF
`define MSS_STEP_DEFAULT    12'h001

`endif

// ---- mss_pkg.sv ----
`default_nettype none
`include "mss_defines.svh"

package mss_pkg;

    typedef enum logic [2:0] {
        MSS_HOLD,
        MSS_MANUAL,
        MSS_TRACK,
        MSS_BLOCK,
        MSS_SAFETY
    } mss_mode_type;

    typedef struct packed {
        logic block_up;
        logic block_down;
    } mss_block_type;

    typedef struct packed {
        logic [2:0] manual_lock_switch;
        logic       manual_track_priority_switch;
        logic [2:0] value_source_switch;
        logic [1:0] output_structure_switch;
    } mss_config_type;

    typedef struct packed {
        logic manual_indication;
        logic tracking_indication;
        logic manual_lamp;
        logic external_value_lamp;
    } mss_signal_type;

    typedef struct packed {
        mss_mode_type                  mode;
        logic [`MSS_VALUE_W-1:0]       y;
        logic                          front_manual;
        logic                          key_prev;
        logic                          ext_prev;
        mss_signal_type                sig;
        logic [`MSS_FLASH_CNT_W-1:0]   flash_cnt;
    } mss_state_type;

endpackage

`default_nettype wire

// ---- mss_mode_select.sv ----
`default_nettype none
`include "mss_defines.svh"

// Operation
// - where a controller would run automatic, this station holds the output instead; other modes act as usual.
// - entering hold keeps the last active output and ignores the up and down keys.
// - with the manual lock switch at 2 the station stays in manual mode and never switches.
// - the slow-pulse lamp is off one tenth and on nine tenths; the manual lamp uses it for an external request alone.
// - the 1:1 lamp flashes evenly; the manual lamp does so in blocking or safety only while manual is requested.
// - the tracking value comes from the analog input at source 0, 1, 4, 5 and from the serial value at 2, 3.
// - with internal position feedback no external tracking value is taken and the last output is held.
// - blocking stops output moves only in the blocked direction and lets the other direction through.
// - safety drives fully open or closed on the two-position structure, else outputs the safety value.
// - with the lock switch at 3 or 4 the external manual request acts on its rising edge like the front key.
// - a newly chosen analog source starts from the output active before the change; a serial source starts from its own value.
// - with priority 1, tracking plus manual gives the manual value, both indications, flashing external lamp.
// - with priority 0, tracking plus manual gives the tracking value, both indications, manual lamp at 1:1.
module mss_mode_select #(
    parameter logic [`MSS_FLASH_CNT_W-1:0] FLASH_PERIOD_CYC = `MSS_FLASH_CNT_W'(`MSS_FLASH_PERIOD_CYC),
    parameter logic [`MSS_VALUE_W-1:0]     STEP             = `MSS_STEP_DEFAULT
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire mss_pkg::mss_config_type    cfg,
    input  wire mss_pkg::mss_block_type     direction_block_inputs,
    input  wire logic                       safety_request,
    input  wire logic                       tracking_select,
    input  wire logic                       manual_request_external,
    input  wire logic                       manual_key_front,
    input  wire logic                       increase_key,
    input  wire logic                       decrease_key,
    input  wire logic [`MSS_VALUE_W-1:0]    tracking_value_analog,
    input  wire logic [`MSS_VALUE_W-1:0]    tracking_value_serial,
    input  wire logic [`MSS_VALUE_W-1:0]    safety_value,
    input  wire logic                       safety_drive_open,
    output logic [`MSS_VALUE_W-1:0]         output_value,
    output mss_pkg::mss_mode_type           active_mode,
    output mss_pkg::mss_signal_type         signals
);
    import mss_pkg::*;

    localparam logic [`MSS_FLASH_CNT_W-1:0] SLOW_OFF_CYC = `MSS_FLASH_CNT_W'(FLASH_PERIOD_CYC / `MSS_SLOW_OFF_DIV);
    localparam logic [`MSS_FLASH_CNT_W-1:0] EVEN_ON_CYC  = `MSS_FLASH_CNT_W'(FLASH_PERIOD_CYC / `MSS_EVEN_DIV);

    mss_state_type st_q;
    mss_state_type st_d;

    function automatic logic serial_source(input logic [2:0] src);
        return (src == `MSS_SRC_SERIAL_A) || (src == `MSS_SRC_SERIAL_B);
    endfunction

    logic                    lock_manual;
    logic                    edge_mode;
    logic                    ext_level;
    logic                    manual_req;
    logic                    int_fb;
    logic                    slow_on;
    logic                    even_on;
    logic [`MSS_VALUE_W-1:0] track_val;
    logic [`MSS_VALUE_W-1:0] base_val;
    logic                    man_wins;

    always_comb begin
        st_d        = st_q;
        lock_manual = cfg.manual_lock_switch == `MSS_LOCK_MANUAL;
        edge_mode   = (cfg.manual_lock_switch == `MSS_LOCK_EDGE_A) || (cfg.manual_lock_switch == `MSS_LOCK_EDGE_B);
        int_fb      = cfg.output_structure_switch == `MSS_STRUCT_INT_FB;
        ext_level   = manual_request_external && !edge_mode;
        // the flash counter runs freely so both lamp patterns share one phase
        st_d.flash_cnt = (st_q.flash_cnt >= FLASH_PERIOD_CYC - 1'b1) ? '0 : st_q.flash_cnt + 1'b1;
        slow_on     = st_q.flash_cnt >= SLOW_OFF_CYC;
        even_on     = st_q.flash_cnt < EVEN_ON_CYC;
        st_d.key_prev = manual_key_front;
        st_d.ext_prev = manual_request_external;
        // front key and, in edge mode, the external request toggle the front manual state
        if ((manual_key_front && !st_q.key_prev) ^ (edge_mode && manual_request_external && !st_q.ext_prev)) begin
            st_d.front_manual = !st_q.front_manual;
        end
        manual_req  = st_q.front_manual || ext_level;
        // serial value taken as it comes; analog source follows us on its own
        track_val   = serial_source(cfg.value_source_switch) ? tracking_value_serial : tracking_value_analog;
        man_wins    = cfg.manual_track_priority_switch;

        if (lock_manual) begin
            st_d.mode = MSS_MANUAL;
        end else if (direction_block_inputs.block_up || direction_block_inputs.block_down) begin
            st_d.mode = MSS_BLOCK;
        end else if (safety_request) begin
            st_d.mode = MSS_SAFETY;
        end else if (tracking_select && !(manual_req && man_wins)) begin
            st_d.mode = MSS_TRACK;
        end else if (manual_req) begin
            st_d.mode = MSS_MANUAL;
        end else begin
            st_d.mode = MSS_HOLD;
        end

        // value the underlying mode would produce; manual steps from st_q.y, tracking takes track_val unless int_fb holds st_q.y
        base_val = st_q.y;
        if (lock_manual || (manual_req && (man_wins || !tracking_select))) begin
            if (increase_key && !decrease_key) begin
                base_val = (st_q.y > `MSS_VALUE_FULL - STEP) ? `MSS_VALUE_FULL : st_q.y + STEP;
            end else if (decrease_key && !increase_key) begin
                base_val = (st_q.y < STEP) ? `MSS_VALUE_RESET : st_q.y - STEP;
            end
        end else if (tracking_select && !int_fb) begin
            base_val = track_val;
        end

        unique case (st_d.mode)
            MSS_HOLD: begin
                st_d.y = st_q.y;
            end
            MSS_MANUAL, MSS_TRACK: begin
                st_d.y = base_val;
            end
            MSS_BLOCK: begin
                st_d.y = base_val;
                if ((direction_block_inputs.block_up && base_val > st_q.y)
                        || (direction_block_inputs.block_down && base_val < st_q.y)) begin
                    st_d.y = st_q.y;
                end
            end
            MSS_SAFETY: begin
                if (cfg.output_structure_switch == `MSS_STRUCT_TWO_POS) begin
                    st_d.y = safety_drive_open ? `MSS_VALUE_FULL : `MSS_VALUE_RESET;
                end else begin
                    st_d.y = safety_value;
                end
            end
        endcase

        unique case (st_d.mode)
            MSS_HOLD: begin
                st_d.sig = '0;
            end
            MSS_MANUAL: begin
                st_d.sig.manual_indication   = 1'b1;
                st_d.sig.tracking_indication = tracking_select && !lock_manual;
                st_d.sig.manual_lamp         = (ext_level && !st_q.front_manual && !lock_manual) ? slow_on : 1'b1;
                st_d.sig.external_value_lamp = st_d.sig.tracking_indication && even_on;
            end
            MSS_TRACK: begin
                st_d.sig.manual_indication   = manual_req;
                st_d.sig.tracking_indication = 1'b1;
                st_d.sig.manual_lamp         = manual_req && even_on;
                st_d.sig.external_value_lamp = 1'b1;
            end
            MSS_BLOCK, MSS_SAFETY: begin
                st_d.sig.manual_indication   = st_q.sig.manual_indication;
                st_d.sig.tracking_indication = 1'b0;
                st_d.sig.manual_lamp         = manual_req && even_on;
                st_d.sig.external_value_lamp = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{mode: MSS_HOLD, y: `MSS_VALUE_RESET, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign output_value = st_q.y;
    assign active_mode  = st_q.mode;
    assign signals      = st_q.sig;

    // checks
    sequence quiet_hold_s;
        !tracking_select && !safety_request && !manual_request_external && !manual_key_front
            && !st_q.front_manual && direction_block_inputs == '0 && cfg.manual_lock_switch == 3'h0;
    endsequence

    sequence block_up_s;
        direction_block_inputs.block_up && !lock_manual;
    endsequence

    hold_keeps_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        quiet_hold_s |=> st_q.mode == MSS_HOLD && st_q.y == $past(st_q.y))
        else $error("hold changed the output");

    hold_all_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        quiet_hold_s |=> st_q.sig == '0)
        else $error("hold with no request lit something");

    lock_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.manual_lock_switch == `MSS_LOCK_MANUAL |=> st_q.mode == MSS_MANUAL)
        else $error("lock 2 left manual mode");

    block_up_a: assert property (@(posedge clk) disable iff (!rst_n)
        block_up_s |=> st_q.y <= $past(st_q.y))
        else $error("output rose while raising was blocked");

    block_down_a: assert property (@(posedge clk) disable iff (!rst_n)
        direction_block_inputs.block_down && !lock_manual |=> st_q.y >= $past(st_q.y))
        else $error("output fell while lowering was blocked");

    block_over_safety_a: assert property (@(posedge clk) disable iff (!rst_n)
        (block_up_s or (direction_block_inputs.block_down && !lock_manual)) |=> st_q.mode == MSS_BLOCK)
        else $error("blocking did not win");

    safety_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        safety_request && !lock_manual && direction_block_inputs == '0
            && cfg.output_structure_switch == 2'h0 |=> st_q.y == $past(safety_value))
        else $error("safety value not output");

    track_serial_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_d.mode == MSS_TRACK && serial_source(cfg.value_source_switch) && !int_fb
            |=> st_q.y == $past(tracking_value_serial))
        else $error("serial tracking value not taken");

    track_int_fb_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_d.mode == MSS_TRACK && int_fb |=> $stable(st_q.y))
        else $error("tracking moved output with internal feedback");

    prio_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_d.mode == MSS_MANUAL && tracking_select && !lock_manual
            |=> st_q.sig.manual_indication && st_q.sig.tracking_indication)
        else $error("manual priority indications wrong");

    prio_track_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_d.mode == MSS_TRACK && manual_req |=> st_q.sig.manual_indication && st_q.sig.tracking_indication)
        else $error("tracking priority indications wrong");

    edge_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
        edge_mode && $rose(manual_request_external) && !(manual_key_front && !st_q.key_prev)
            |=> st_q.front_manual != $past(st_q.front_manual))
        else $error("external edge did not toggle manual");

    even_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.flash_cnt == EVEN_ON_CYC && (st_d.mode == MSS_SAFETY || st_d.mode == MSS_BLOCK) && manual_req
            |=> !st_q.sig.manual_lamp)
        else $error("1:1 lamp on in its off half");

endmodule

`default_nettype wire

// ---- mss_partner_model.sv ----
`default_nettype none
`include "mss_defines.svh"

module mss_partner_model (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic [`MSS_VALUE_W-1:0] output_value,
    input  wire logic                    tracking_select,
    output logic      [`MSS_VALUE_W-1:0] tracking_value_analog
);
    timeunit 1ns;
    timeprecision 1ns;
    // the analog feeder follows the station while not asked to lead it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tracking_value_analog <= `MSS_VALUE_RESET;
        end else if (!tracking_select) begin
            tracking_value_analog <= output_value;
        end
    end
endmodule

`default_nettype wire

// ---- tb_manual_station_output_mode_select.sv ----
`default_nettype none
`include "mss_defines.svh"
`define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
        error_cnt++; \
        $display("Error %0t: %0h vs %0h", $time, a, e); \
    end \
end

module tb_manual_station_output_mode_select;
    timeunit 1ns;
    timeprecision 1ns;
    import mss_pkg::*;
    localparam logic [`MSS_VALUE_W-1:0] STEP = `MSS_STEP_DEFAULT;
    logic                    clk, rst_n, safety_request, tracking_select, manual_request_external;
    logic                    manual_key_front, increase_key, decrease_key, safety_drive_open;
    mss_config_type          cfg;
    mss_block_type           blk;
    logic [`MSS_VALUE_W-1:0] tracking_value_analog, tracking_value_serial, safety_value, output_value, v, w;
    mss_mode_type            active_mode;
    mss_signal_type          signals;
    logic [2:0]              srcs [6] = '{3'h2, 3'h0, 3'h3, 3'h1, 3'h4, 3'h5};
    integer                  seed = 86094;
    int                      error_cnt = 0, comparisons = 0, cyc = 0, n;

    mss_mode_select #(.FLASH_PERIOD_CYC(26'd100), .STEP(STEP)) dut (
        .clk(clk), .rst_n(rst_n), .cfg(cfg), .direction_block_inputs(blk), .safety_request(safety_request),
        .tracking_select(tracking_select), .manual_request_external(manual_request_external),
        .manual_key_front(manual_key_front), .increase_key(increase_key), .decrease_key(decrease_key),
        .tracking_value_analog(tracking_value_analog), .tracking_value_serial(tracking_value_serial),
        .safety_value(safety_value), .safety_drive_open(safety_drive_open), .output_value(output_value),
        .active_mode(active_mode), .signals(signals));
    mss_partner_model partner (.clk(clk), .rst_n(rst_n), .output_value(output_value),
        .tracking_select(tracking_select), .tracking_value_analog(tracking_value_analog));

    function automatic mss_signal_type sig(input int mi, ti, ml, el);
        return {mi[0], ti[0], ml[0], el[0]};
    endfunction
    function automatic logic [`MSS_VALUE_W-1:0] src_exp(input logic [2:0] s, input logic [`MSS_VALUE_W-1:0] a, b);
        return (s == `MSS_SRC_SERIAL_A || s == `MSS_SRC_SERIAL_B) ? b : a;
    endfunction
    task automatic t(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // a full flash period, so the phase of the counter does not matter
    task automatic lamp(input bit ext);
        n = 0;
        repeat (100) begin
            @(posedge clk);
            #1;
            n += ext ? int'(signals.external_value_lamp) : int'(signals.manual_lamp);
        end
    endtask
    task automatic key;
        @(posedge clk);
        manual_key_front <= 1'b1;
        @(posedge clk);
        manual_key_front <= 1'b0;
        t(1);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            end_sim;
        end
    end

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        blk = '0;
        {safety_request, tracking_select, manual_request_external, manual_key_front} = '0;
        {increase_key, decrease_key, safety_drive_open, tracking_value_serial, safety_value} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t(1);
        `CHK(active_mode, MSS_HOLD)
        `CHK(signals, sig(0, 0, 0, 0))
        foreach (srcs[i]) begin
            @(posedge clk);
            increase_key <= 1'b0;
            cfg.value_source_switch <= srcs[i];
            tracking_value_serial <= `MSS_VALUE_W'($random(seed)) & 12'h7FF;
            tracking_select <= 1'b1;
            t(1);
            `CHK(output_value, src_exp(srcs[i], tracking_value_analog, tracking_value_serial))
            `CHK(signals, sig(0, 1, 0, 1))
            v = output_value;
            @(posedge clk);
            tracking_select <= 1'b0;
            increase_key <= 1'b1;
            t(2);
            `CHK(output_value, v)
        end
        $display("tracking and hold test done");
        @(posedge clk);
        increase_key <= 1'b0;
        cfg.output_structure_switch <= `MSS_STRUCT_INT_FB;
        cfg.value_source_switch <= `MSS_SRC_SERIAL_A;
        tracking_value_serial <= ~v;
        tracking_select <= 1'b1;
        t(2);
        `CHK(output_value, v)
        @(posedge clk);
        tracking_select <= 1'b0;
        cfg.output_structure_switch <= 2'h0;
        key;
        `CHK(output_value, v)
        `CHK(signals, sig(1, 0, 1, 0))
        @(posedge clk);
        increase_key <= 1'b1;
        t(4);
        @(posedge clk);
        increase_key <= 1'b0;
        t(1);
        `CHK(output_value, v + 12'h005 * STEP)
        v = output_value;
        @(posedge clk);
        blk <= 2'b10;
        decrease_key <= 1'b1;
        t(2);
        @(posedge clk);
        decrease_key <= 1'b0;
        increase_key <= 1'b1;
        t(1);
        `CHK(output_value, v - 12'h003 * STEP)
        `CHK(active_mode, MSS_BLOCK)
        `CHK(signals.manual_indication, 1'b1)
        lamp(0);
        `CHK(n, 50)
        `CHK(output_value, v - 12'h003 * STEP)
        $display("manual and blocking test done");
        w = `MSS_VALUE_W'($random(seed));
        @(posedge clk);
        {blk, increase_key} <= '0;
        safety_request <= 1'b1;
        safety_value <= w;
        t(2);
        `CHK(output_value, w)
        `CHK(active_mode, MSS_SAFETY)
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            cfg.output_structure_switch <= `MSS_STRUCT_TWO_POS;
            safety_drive_open <= i[0];
            t(2);
            `CHK(output_value, i ? `MSS_VALUE_FULL : `MSS_VALUE_RESET)
        end
        @(posedge clk);
        blk <= 2'b01;
        decrease_key <= 1'b1;
        t(2);
        `CHK(active_mode, MSS_BLOCK)
        `CHK(output_value, `MSS_VALUE_FULL)
        $display("safety test done");
        w = `MSS_VALUE_W'($random(seed));
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            {blk, safety_request, decrease_key, cfg.output_structure_switch} <= '0;
            cfg.manual_track_priority_switch <= p[0];
            tracking_value_serial <= w;
            tracking_select <= 1'b1;
            t(2);
            `CHK(active_mode, p ? MSS_MANUAL : MSS_TRACK)
            `CHK(output_value, w)
            `CHK({signals.manual_indication, signals.tracking_indication}, 2'b11)
            lamp(p[0]);
            `CHK(n, 50)
        end
        @(posedge clk);
        tracking_select <= 1'b0;
        key;
        `CHK(signals, sig(0, 0, 0, 0))
        @(posedge clk);
        manual_request_external <= 1'b1;
        t(2);
        `CHK(active_mode, MSS_MANUAL)
        lamp(0);
        `CHK(n, 90)
        $display("priority and lamp test done");
        @(posedge clk);
        cfg.manual_lock_switch <= `MSS_LOCK_EDGE_A;
        manual_request_external <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            cfg.manual_lock_switch <= k ? `MSS_LOCK_EDGE_B : `MSS_LOCK_EDGE_A;
            manual_request_external <= 1'b1;
            @(posedge clk);
            manual_request_external <= 1'b0;
            t(2);
            `CHK(active_mode, k ? MSS_HOLD : MSS_MANUAL)
        end
        @(posedge clk);
        cfg.manual_lock_switch <= `MSS_LOCK_MANUAL;
        tracking_select <= 1'b1;
        safety_request <= 1'b1;
        t(2);
        `CHK(active_mode, MSS_MANUAL)
        $display("lock test done");
        end_sim;
    end
endmodule

`default_nettype wire
